// file: core/host_port_pkg.sv
// Shared constants and carrier types for the router host-side pin logic
package host_port_pkg;

	// ************************************************************
	// Word and time-code carriers
	// ************************************************************
	typedef struct packed
	{
		logic       marker;
		logic [7:0] data;
	} host_word_t;

	typedef struct packed
	{
		logic       tick;
		logic       load_sel;
		logic       clear;
		logic [7:0] value;
	} tc_pins_t;

	typedef enum {ST_STRAP_WAIT, ST_DRIVE} status_phase_t;

	// ************************************************************
	// Sizes, timing and reset values
	// ************************************************************
	localparam int         WORD_W         = 9;
	localparam int         FIFO_DEPTH     = 16;
	localparam int         CLK_PERIOD_PS  = 5000;
	localparam int         TICK_LOW_NS    = 20;
	localparam int         STRAP_WAIT_NS  = 40;
	localparam int         TICK_LOW_CYC   = (TICK_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int         STRAP_WAIT_CYC = (STRAP_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [7:0] TC_RESET       = 8'h00;
	localparam logic [7:0] STATUS_RESET   = 8'h00;

	// ************************************************************
	// Status group select codes
	// ************************************************************
	localparam logic [3:0] GRP_STRAP      = 4'h0;
	localparam logic [3:0] GRP_ERRORS     = 4'h1;
	localparam logic [3:0] GRP_FIFO_FLAGS = 4'h2;
	localparam logic [3:0] GRP_TC_COUNT   = 4'h3;
	localparam logic [3:0] GRP_TC_LAST    = 4'h4;

	// Error bit positions in GRP_ERRORS
	localparam int ERR_P0_OVERRUN  = 0;
	localparam int ERR_P0_UNDERRUN = 1;
	localparam int ERR_P1_OVERRUN  = 2;
	localparam int ERR_P1_UNDERRUN = 3;
	localparam int ERR_TC_SEQUENCE = 4;

endpackage : host_port_pkg

// file: core/host_port.sv
// Host FIFO ports, time-code pins and status bus of the router
`timescale 1ns/1ps

// ************************************************************
// Word FIFO
// ************************************************************
module word_fifo
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
)
(
	input  wire logic             ref_clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             wr_valid_i,
	output logic                  wr_ready_o,
	input  wire logic [WIDTH-1:0] wr_data_i,
	output logic                  rd_valid_o,
	input  wire logic             rd_ready_i,
	output logic      [WIDTH-1:0] rd_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      count_ff;
	logic             do_wr;
	logic             do_rd;

	assign wr_ready_o = (count_ff != (AW+1)'(DEPTH));
	assign rd_valid_o = (count_ff != '0);
	assign rd_data_o  = mem_ff[rd_ptr_ff];
	assign do_wr      = wr_valid_i && wr_ready_o;
	assign do_rd      = rd_valid_o && rd_ready_i;

	always_ff @(posedge ref_clk_i)
	begin
		if (do_wr)
			mem_ff[wr_ptr_ff] <= wr_data_i;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end
		else
		begin
			if (do_wr)
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
			if (do_rd)
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
			if (do_wr && !do_rd)
				count_ff <= count_ff + 1'b1;
			else if (do_rd && !do_wr)
				count_ff <= count_ff - 1'b1;
		end
	end
endmodule : word_fifo

// ************************************************************
// Host-side port logic
// ************************************************************
// Contract
// - Reset initialises all logic except the FIFO word storage, regardless of activity
// - Everything runs from the one system clock
// - Nine-bit words, top bit marks end marker
// - Output availability high while word held
// - Input space flag high while not full
// - Two identical independent host ports
// - Rising tick request edge sends time-code
// - Load select at tick loads external value
// - Counter clear forces time-code counter zero
// - Falling tick indicate edge marks reception
// - Time value out valid while tick low
// - Group select picks status bus content
// - Status pins sampled as straps, then driven
// - Highest numbered bus bit is MSB
// - FIFO accesses synchronous to system clock
// - Slave tick only when value is plus one
module host_port
	import host_port_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       sys_rst_i,
	input  wire host_word_t host0_in_word_i,
	input  wire logic       host0_push_n_i,
	output logic            host0_in_space_o,
	output host_word_t      host0_out_word_o,
	input  wire logic       host0_pop_n_i,
	output logic            host0_out_avail_o,
	input  wire host_word_t host1_in_word_i,
	input  wire logic       host1_push_n_i,
	output logic            host1_in_space_o,
	output host_word_t      host1_out_word_o,
	input  wire logic       host1_pop_n_i,
	output logic            host1_out_avail_o,
	output host_word_t      rtr0_in_word_o,
	output logic            rtr0_in_valid_o,
	input  wire logic       rtr0_in_ready_i,
	input  wire host_word_t rtr0_out_word_i,
	input  wire logic       rtr0_out_valid_i,
	output logic            rtr0_out_ready_o,
	output host_word_t      rtr1_in_word_o,
	output logic            rtr1_in_valid_o,
	input  wire logic       rtr1_in_ready_i,
	input  wire host_word_t rtr1_out_word_i,
	input  wire logic       rtr1_out_valid_i,
	output logic            rtr1_out_ready_o,
	input  wire logic       tc_tick_request_i,
	input  wire logic [7:0] tc_value_in_i,
	input  wire logic       tc_load_select_i,
	input  wire logic       tc_counter_clear_i,
	output logic            tc_tick_indicate_o,
	output logic      [7:0] tc_value_out_o,
	output logic            tc_send_o,
	output logic      [7:0] tc_send_value_o,
	input  wire logic       tc_rx_valid_i,
	input  wire logic [7:0] tc_rx_value_i,
	input  wire logic [3:0] status_group_select_i,
	input  wire logic [7:0] status_bus_i,
	output logic      [7:0] status_bus_o,
	output logic            status_bus_oe_n_o,
	output logic      [7:0] strap_config_o
);
	function automatic logic [7:0] tc_next(input logic [7:0] v);
		tc_next = v + 8'h01;
	endfunction : tc_next

	// ************************************************************
	// Host FIFO ports
	// ************************************************************
	logic p0_push;
	logic p1_push;
	logic p0_pop;
	logic p1_pop;

	assign p0_push = !host0_push_n_i && host0_in_space_o;
	assign p1_push = !host1_push_n_i && host1_in_space_o;
	assign p0_pop  = !host0_pop_n_i && host0_out_avail_o;
	assign p1_pop  = !host1_pop_n_i && host1_out_avail_o;

	word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_p0_in
	(
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.wr_valid_i(p0_push),
		.wr_ready_o(host0_in_space_o),
		.wr_data_i (host0_in_word_i),
		.rd_valid_o(rtr0_in_valid_o),
		.rd_ready_i(rtr0_in_ready_i),
		.rd_data_o (rtr0_in_word_o)
	);

	word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_p0_out
	(
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.wr_valid_i(rtr0_out_valid_i),
		.wr_ready_o(rtr0_out_ready_o),
		.wr_data_i (rtr0_out_word_i),
		.rd_valid_o(host0_out_avail_o),
		.rd_ready_i(p0_pop),
		.rd_data_o (host0_out_word_o)
	);

	word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_p1_in
	(
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.wr_valid_i(p1_push),
		.wr_ready_o(host1_in_space_o),
		.wr_data_i (host1_in_word_i),
		.rd_valid_o(rtr1_in_valid_o),
		.rd_ready_i(rtr1_in_ready_i),
		.rd_data_o (rtr1_in_word_o)
	);

	word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_p1_out
	(
		.ref_clk_i (ref_clk_i),
		.sys_rst_i (sys_rst_i),
		.wr_valid_i(rtr1_out_valid_i),
		.wr_ready_o(rtr1_out_ready_o),
		.wr_data_i (rtr1_out_word_i),
		.rd_valid_o(host1_out_avail_o),
		.rd_ready_i(p1_pop),
		.rd_data_o (host1_out_word_o)
	);

	// ************************************************************
	// Time-code pin synchronisers
	// ************************************************************
	tc_pins_t tc_meta_ff;
	tc_pins_t tc_sync_ff;
	logic     tick_prev_ff;
	logic     tick_rise;

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			tc_meta_ff   <= '0;
			tc_sync_ff   <= '0;
			tick_prev_ff <= 1'b0;
		end
		else
		begin
			tc_meta_ff   <= {tc_tick_request_i, tc_load_select_i, tc_counter_clear_i, tc_value_in_i};
			tc_sync_ff   <= tc_meta_ff;
			tick_prev_ff <= tc_sync_ff.tick;
		end
	end

	assign tick_rise = tc_sync_ff.tick && !tick_prev_ff;

	// ************************************************************
	// Time-code counter, send and receive
	// ************************************************************
	logic [7:0]                      tc_count_ff;
	logic [$clog2(TICK_LOW_CYC+1):0] tick_low_ff;
	logic                            rx_in_order;

	assign rx_in_order = tc_rx_valid_i && (tc_rx_value_i == tc_next(tc_count_ff));

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			tc_count_ff     <= TC_RESET;
			tc_send_o       <= 1'b0;
			tc_send_value_o <= TC_RESET;
		end
		else
		begin
			tc_send_o <= tick_rise;
			if (tc_sync_ff.clear)
				tc_count_ff <= TC_RESET;
			else if (tick_rise && tc_sync_ff.load_sel)
				tc_count_ff <= tc_sync_ff.value;
			else if (tick_rise)
				tc_count_ff <= tc_next(tc_count_ff);
			else if (tc_rx_valid_i)
				tc_count_ff <= tc_rx_value_i;
			if (tick_rise)
				tc_send_value_o <= tc_sync_ff.load_sel ? tc_sync_ff.value : tc_next(tc_count_ff);
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			tick_low_ff        <= '0;
			tc_tick_indicate_o <= 1'b1;
			tc_value_out_o     <= TC_RESET;
		end
		else if (rx_in_order && !tc_sync_ff.clear)
		begin
			tick_low_ff        <= ($bits(tick_low_ff))'(TICK_LOW_CYC);
			tc_tick_indicate_o <= 1'b0;
			tc_value_out_o     <= tc_rx_value_i;
		end
		else if (tick_low_ff != '0)
		begin
			tick_low_ff        <= tick_low_ff - 1'b1;
			tc_tick_indicate_o <= (tick_low_ff == 1);
		end
	end

	// ************************************************************
	// Status bus: strap capture, then driven group mux
	// ************************************************************
	status_phase_t                     phase_ff;
	logic [$clog2(STRAP_WAIT_CYC+1):0] strap_cnt_ff;
	logic [7:0]                        strap_meta_ff;
	logic [7:0]                        strap_sync_ff;
	logic [7:0]                        err_ff;
	logic [7:0]                        nxt_status;

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			strap_meta_ff <= '0;
			strap_sync_ff <= '0;
		end
		else
		begin
			strap_meta_ff <= status_bus_i;
			strap_sync_ff <= strap_meta_ff;
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			phase_ff          <= ST_STRAP_WAIT;
			strap_cnt_ff      <= '0;
			strap_config_o    <= STATUS_RESET;
			status_bus_oe_n_o <= 1'b1;
		end
		else
		begin
			case (phase_ff)
				ST_STRAP_WAIT:
				begin
					strap_cnt_ff <= strap_cnt_ff + 1'b1;
					if (strap_cnt_ff == ($bits(strap_cnt_ff))'(STRAP_WAIT_CYC - 1))
					begin
						strap_config_o    <= strap_sync_ff;
						status_bus_oe_n_o <= 1'b0;
						phase_ff          <= ST_DRIVE;
					end
				end
				ST_DRIVE:
					status_bus_oe_n_o <= 1'b0;
				default:
					phase_ff <= ST_STRAP_WAIT;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			err_ff <= '0;
		else
		begin
			if (!host0_push_n_i && !host0_in_space_o)
				err_ff[ERR_P0_OVERRUN] <= 1'b1;
			if (!host0_pop_n_i && !host0_out_avail_o)
				err_ff[ERR_P0_UNDERRUN] <= 1'b1;
			if (!host1_push_n_i && !host1_in_space_o)
				err_ff[ERR_P1_OVERRUN] <= 1'b1;
			if (!host1_pop_n_i && !host1_out_avail_o)
				err_ff[ERR_P1_UNDERRUN] <= 1'b1;
			if (tc_rx_valid_i && !rx_in_order)
				err_ff[ERR_TC_SEQUENCE] <= 1'b1;
		end
	end

	always_comb
	begin
		case (status_group_select_i)
			GRP_STRAP:      nxt_status = strap_config_o;
			GRP_ERRORS:     nxt_status = err_ff;
			GRP_FIFO_FLAGS: nxt_status = {4'h0, host1_out_avail_o, host1_in_space_o,
			                              host0_out_avail_o, host0_in_space_o};
			GRP_TC_COUNT:   nxt_status = tc_count_ff;
			GRP_TC_LAST:    nxt_status = tc_value_out_o;
			default:        nxt_status = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i || phase_ff != ST_DRIVE)
			status_bus_o <= STATUS_RESET;
		else
			status_bus_o <= nxt_status;
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	push_accept_a: assert property (p0_push |-> ##1 rtr0_in_valid_o) else $error("push lost");
	avail_flag_a: assert property (rtr0_out_valid_i && rtr0_out_ready_o |=> host0_out_avail_o)
		else $error("avail low after fill");
	space_flag_a: assert property (host1_in_space_o && !p1_push |=> host1_in_space_o)
		else $error("space lost without push");
	pop_word_a: assert property (p0_pop && !(rtr0_out_valid_i && rtr0_out_ready_o)
		|=> u_p0_out.count_ff == $past(u_p0_out.count_ff) - 1'b1) else $error("pop not counted");
	tick_load_a: assert property (tick_rise && tc_sync_ff.load_sel && !tc_sync_ff.clear
		|=> tc_count_ff == $past(tc_sync_ff.value) && tc_send_o) else $error("no load");
	tc_clear_a: assert property (tc_sync_ff.clear |=> tc_count_ff == 8'h00) else $error("no clear");
	tick_pulse_a: assert property (rx_in_order && !tc_sync_ff.clear
		|=> !tc_tick_indicate_o [*4] ##1 tc_tick_indicate_o) else $error("tick width");
	tick_value_a: assert property (!tc_tick_indicate_o
		|-> $stable(tc_value_out_o) || $fell(tc_tick_indicate_o)) else $error("value moved");
	slave_skip_a: assert property (tc_rx_valid_i && !rx_in_order && tc_tick_indicate_o
		&& tick_low_ff == '0 |=> tc_tick_indicate_o) else $error("bad tick");
	strap_drive_a: assert property ($fell(status_bus_oe_n_o)
		|-> strap_config_o == $past(strap_sync_ff)) else $error("strap");
	status_mux_a: assert property (phase_ff == ST_DRIVE
		&& status_group_select_i == GRP_TC_COUNT |=> status_bus_o == $past(tc_count_ff))
		else $error("status mux");

	fill_c: cover property (!host0_in_space_o);
	tick_c: cover property (tick_rise ##1 tc_send_o);
	rx_c: cover property ($fell(tc_tick_indicate_o));
	drive_c: cover property ($fell(status_bus_oe_n_o));
endmodule : host_port

// file: verification/router_core_model.sv
// Router-core side model that sinks and sources host FIFO words
`timescale 1ns/1ps

module router_core_model
	import host_port_pkg::*;
(
	input  wire logic       ref_clk_i,
	input  wire logic       stall_i,
	input  wire host_word_t in_word_i,
	input  wire logic       in_valid_i,
	output logic            in_ready_o,
	output host_word_t      out_word_o,
	output logic            out_valid_o,
	input  wire logic       out_ready_i
);
	host_word_t got_q[$];
	host_word_t send_q[$];

	initial
	begin
		in_ready_o  = 1'b0;
		out_valid_o = 1'b0;
		out_word_o  = '0;
	end

	// ************************************************************
	// Valid/ready on both sides, idle word toggles each cycle
	// ************************************************************
	always @(posedge ref_clk_i)
	begin
		if (in_valid_i && in_ready_o)
			got_q.push_back(in_word_i);
		if (out_valid_o && out_ready_i)
			void'(send_q.pop_front());
		in_ready_o <= !stall_i;
		if (send_q.size() != 0)
		begin
			out_valid_o <= 1'b1;
			out_word_o  <= send_q[0];
		end
		else
		begin
			out_valid_o <= 1'b0;
			out_word_o  <= host_word_t'(~out_word_o);
		end
	end
endmodule : router_core_model

// file: verification/testbench.sv
// Self-checking bench for the host port block
`timescale 1ns/1ps

module testbench
	import host_port_pkg::*;
;
	localparam logic [7:0] STRAP_VAL = 8'ha5;
	logic       clk = 1'b0, rst = 1'b1, tick = 1'b0, ld = 1'b0, clr = 1'b0, rxv = 1'b0;
	logic [7:0] tval = 8'h00, rxval = 8'h00, pin, tvo, tsv, sbo, strap;
	logic [3:0] gsel = 4'h0;
	logic       push_n[2] = '{1'b1, 1'b1};
	logic       pop_n[2] = '{1'b1, 1'b1};
	logic       stall[2] = '{1'b1, 1'b1};
	host_word_t in_w[2] = '{'0, '0};
	logic       space[2], avail[2], riv[2], rir[2], rov[2], ror[2], tind, tsend, oe_n;
	host_word_t out_w[2], riw[2], row[2];
	int         num_errors = 0, checks_done = 0;

	assign pin = oe_n ? STRAP_VAL : sbo;
	always #2.5 clk = ~clk;

	host_port dut_u
	(
		.ref_clk_i(clk), .sys_rst_i(rst),
		.host0_in_word_i(in_w[0]), .host0_push_n_i(push_n[0]), .host0_in_space_o(space[0]),
		.host0_out_word_o(out_w[0]), .host0_pop_n_i(pop_n[0]), .host0_out_avail_o(avail[0]),
		.host1_in_word_i(in_w[1]), .host1_push_n_i(push_n[1]), .host1_in_space_o(space[1]),
		.host1_out_word_o(out_w[1]), .host1_pop_n_i(pop_n[1]), .host1_out_avail_o(avail[1]),
		.rtr0_in_word_o(riw[0]), .rtr0_in_valid_o(riv[0]), .rtr0_in_ready_i(rir[0]),
		.rtr0_out_word_i(row[0]), .rtr0_out_valid_i(rov[0]), .rtr0_out_ready_o(ror[0]),
		.rtr1_in_word_o(riw[1]), .rtr1_in_valid_o(riv[1]), .rtr1_in_ready_i(rir[1]),
		.rtr1_out_word_i(row[1]), .rtr1_out_valid_i(rov[1]), .rtr1_out_ready_o(ror[1]),
		.tc_tick_request_i(tick), .tc_value_in_i(tval), .tc_load_select_i(ld),
		.tc_counter_clear_i(clr), .tc_tick_indicate_o(tind), .tc_value_out_o(tvo),
		.tc_send_o(tsend), .tc_send_value_o(tsv), .tc_rx_valid_i(rxv), .tc_rx_value_i(rxval),
		.status_group_select_i(gsel), .status_bus_i(pin), .status_bus_o(sbo),
		.status_bus_oe_n_o(oe_n), .strap_config_o(strap)
	);

	router_core_model pm0
	(
		.ref_clk_i(clk), .stall_i(stall[0]), .in_word_i(riw[0]), .in_valid_i(riv[0]),
		.in_ready_o(rir[0]), .out_word_o(row[0]), .out_valid_o(rov[0]), .out_ready_i(ror[0])
	);

	router_core_model pm1
	(
		.ref_clk_i(clk), .stall_i(stall[1]), .in_word_i(riw[1]), .in_valid_i(riv[1]),
		.in_ready_o(rir[1]), .out_word_o(row[1]), .out_valid_o(rov[1]), .out_ready_i(ror[1])
	);

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	function automatic host_word_t got_at(input int p, input int i);
		return p ? pm1.got_q[i] : pm0.got_q[i];
	endfunction : got_at

	task automatic grp(input logic [3:0] sel, input logic [7:0] exp);
		@(posedge clk) gsel <= sel;
		repeat (2) @(posedge clk);
		#1 check("status group", exp, sbo);
	endtask : grp

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : print_verdict

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset;
		#1 check("space", 1, space[0]);
		check("avail", 0, avail[1]);
		check("tick idle", 1, tind);
		check("pins input", 1, oe_n);
		repeat (10) @(posedge clk);
		#1 check("pins driven", 0, oe_n);
		check("strap", STRAP_VAL, strap);
		grp(GRP_STRAP, STRAP_VAL);
		grp(4'hf, 8'h00);
		$display("reset test done");
	endtask : t_reset

	task automatic t_fill(input int p, input logic [7:0] err);
		for (int i = 0; i < 17; i++)
			@(posedge clk)
			begin
				push_n[p] <= 1'b0;
				in_w[p]   <= {i == 15, 8'(p * 16 + i)};
			end
		@(posedge clk) push_n[p] <= 1'b1;
		#1 check("space full", 0, space[p]);
		check("other space", 1, space[1 - p]);
		stall[p] <= 1'b0;
		repeat (40) @(posedge clk);
		#1 check("space back", 1, space[p]);
		check("word count", 16, p ? pm1.got_q.size() : pm0.got_q.size());
		for (int i = 0; i < 16; i++)
			check("word", {i == 15, 8'(p * 16 + i)}, got_at(p, i));
		stall[p] <= 1'b1;
		grp(GRP_ERRORS, err);
		$display("fill test done");
	endtask : t_fill

	task automatic t_pop(input int p);
		for (int i = 0; i < 3; i++)
			if (p)
				pm1.send_q.push_back({i == 2, 8'(8'h40 + i)});
			else
				pm0.send_q.push_back({i == 2, 8'(8'h40 + i)});
		repeat (8) @(posedge clk);
		@(posedge clk) pop_n[p] <= 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			@(negedge clk) check("out word", {i == 2, 8'(8'h40 + i)}, out_w[p]);
			check("avail", 1, avail[p]);
		end
		@(posedge clk) pop_n[p] <= 1'b1;
		@(negedge clk) check("avail empty", 0, avail[p]);
		grp(GRP_FIFO_FLAGS, 8'h05);
		$display("pop test done");
	endtask : t_pop

	task automatic tick_once(input logic load, input logic [7:0] val, input logic [7:0] exp);
		int n;
		n = 0;
		@(posedge clk)
		begin
			ld   <= load;
			tval <= val;
		end
		repeat (2) @(posedge clk);
		@(posedge clk) tick <= 1'b1;
		while (tsend !== 1'b1 && n < 12)
		begin
			@(negedge clk);
			n++;
		end
		check("send seen", 1, tsend);
		check("send value", exp, tsv);
		@(posedge clk) tick <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : tick_once

	task automatic t_master;
		tick_once(1'b1, 8'h3c, 8'h3c);
		tick_once(1'b0, 8'h99, 8'h3d);
		@(posedge clk) clr <= 1'b1;
		repeat (4) @(posedge clk);
		@(posedge clk) clr <= 1'b0;
		repeat (4) @(posedge clk);
		tick_once(1'b0, 8'h99, 8'h01);
		grp(GRP_TC_COUNT, 8'h01);
		$display("master test done");
	endtask : t_master

	task automatic rx_code(input logic [7:0] v, input logic ind);
		@(posedge clk)
		begin
			rxv   <= 1'b1;
			rxval <= v;
		end
		@(posedge clk) rxv <= 1'b0;
		#1 check("tick low", !ind, tind);
		if (ind)
			check("time out", v, tvo);
		repeat (3) @(posedge clk);
		#1 check("tick held", !ind, tind);
		@(posedge clk);
		#1 check("tick back", 1, tind);
	endtask : rx_code

	task automatic t_slave(input logic [7:0] err);
		rx_code(8'h02, 1'b1);
		rx_code(8'h07, 1'b0);
		grp(GRP_TC_COUNT, 8'h07);
		grp(GRP_ERRORS, err | 8'(1 << ERR_TC_SEQUENCE));
		rx_code(8'h08, 1'b1);
		grp(GRP_TC_LAST, 8'h08);
		$display("slave test done");
	endtask : t_slave

	task automatic t_rerun;
		@(posedge clk) rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1 check("rerun pins input", 1, oe_n);
		check("rerun bus", 8'h00, sbo);
		check("rerun tick idle", 1, tind);
		repeat (10) @(posedge clk);
		#1 check("rerun strap", STRAP_VAL, strap);
		grp(GRP_ERRORS, 8'h00);
		grp(GRP_TC_COUNT, 8'h00);
		$display("rerun test done");
	endtask : t_rerun

	// ************************************************************
	// Main sequence and watchdog
	// ************************************************************
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_fill(0, 8'(1 << ERR_P0_OVERRUN));
		t_fill(1, 8'((1 << ERR_P0_OVERRUN) | (1 << ERR_P1_OVERRUN)));
		t_pop(0);
		t_pop(1);
		t_master();
		t_slave(8'((1 << ERR_P0_OVERRUN) | (1 << ERR_P1_OVERRUN)));
		t_rerun();
		print_verdict();
	end

	initial
	begin
		#(4000 * 5);
		num_errors++;
		print_verdict();
	end
endmodule : testbench
